// ### shared/flash_erase_pkg.sv
package flash_erase_pkg;
   // ****************************************
   // Flash bus layout
   // ****************************************
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam int SECT_W = 5;
   localparam int NUM_SECT = 32;
   localparam int SECT_LSB = 12;
   localparam logic [16:0] UNLOCK_ADDR1 = 17'h00555;
   localparam logic [16:0] UNLOCK_ADDR2 = 17'h002aa;
   localparam logic [7:0] UNLOCK_DATA1 = 8'haa;
   localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
   localparam logic [7:0] CMD_SETUP = 8'h80;
   localparam logic [7:0] CMD_SECT_ERASE = 8'h30;
   localparam logic [7:0] CMD_SUSPEND = 8'hb0;
   localparam logic [7:0] CMD_RESUME = 8'h30;
   localparam logic [2:0] LAST_STEP = 3'h5;
   // Status byte positions
   localparam int POLL_BIT = 7;
   localparam int TOGGLE_BIT = 6;
   localparam int WINDOW_BIT = 3;
   localparam int SECT_TOGGLE_BIT = 2;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_NS = 40;
   localparam int WINDOW_US = 50;
   localparam int SUSPEND_US = 20;
   localparam int ACCESS_NS = 55;
   localparam int WE_PULSE_NS = 80;
   localparam int RESET_PULSE_NS = 500;
   localparam int RESET_READY_NS = 20000;
   localparam logic [15:0] WINDOW_CYC = 16'(WINDOW_US * 1000 / CLK_NS);
   localparam logic [15:0] SUSPEND_CYC = 16'((SUSPEND_US * 1000 + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] RD_CYC = 16'((ACCESS_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] WE_CYC = 16'((WE_PULSE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] RESET_PULSE_CYC = 16'((RESET_PULSE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] RESET_READY_CYC = 16'((RESET_READY_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] POLL_GAP_CYC = 16'h0064;
   // ****************************************
   // Software registers
   // ****************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_SECT_MASK = 8'h04;
   localparam logic [7:0] REG_RD_ADDR = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_RD_DATA = 8'h10;
   localparam int CTRL_ERASE = 0;
   localparam int CTRL_SUSPEND = 1;
   localparam int CTRL_RESUME = 2;
   localparam int CTRL_HW_RESET = 3;
   localparam int CTRL_READ = 4;
   localparam int CTRL_DONE_CLR = 5;
   // ****************************************
   // Types
   // ****************************************
   typedef enum {OP_ERASE, OP_SUSPEND, OP_RESUME, OP_READ} op_e;
   typedef enum {ST_IDLE, ST_SET, ST_WE, ST_HOLD, ST_RD, ST_SAMPLE, ST_SUSP_WAIT, ST_RST, ST_RST_WAIT} state_e;
   typedef struct packed {
      logic [16:0] addr;
      logic [7:0] data;
   } busWord_s;
endpackage : flash_erase_pkg

// ### verilog/sector_erase_host.sv
`timescale 1ns/1ps
module sector_erase_host
   import flash_erase_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdData,
   output logic [16:0] flashAddr,
   input wire logic [7:0] flashDqIn,
   output logic [7:0] flashDqOut,
   output logic flashDqOe,
   output logic flashCeN,
   output logic flashOeN,
   output logic flashWeN,
   output logic flashResetN
);
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [16:0] sectAddr(input logic [4:0] s);
      return {s, 12'h000};
   endfunction : sectAddr

   function automatic logic [4:0] firstSet(input logic [31:0] m);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 31; i >= 0; i--) begin
         if (m[i]) begin
            r = 5'(i);
         end
      end
      return r;
   endfunction : firstSet

   function automatic busWord_s seqWord(input logic [2:0] step, input logic [4:0] s);
      busWord_s w;
      case (step)
         3'h0: w = '{UNLOCK_ADDR1, UNLOCK_DATA1};
         3'h1: w = '{UNLOCK_ADDR2, UNLOCK_DATA2};
         3'h2: w = '{UNLOCK_ADDR1, CMD_SETUP};
         3'h3: w = '{UNLOCK_ADDR1, UNLOCK_DATA1};
         3'h4: w = '{UNLOCK_ADDR2, UNLOCK_DATA2};
         default: w = '{sectAddr(s), CMD_SECT_ERASE};
      endcase
      return w;
   endfunction : seqWord

   state_e stateReg;
   op_e opReg;
   logic [2:0] stepReg;
   logic [15:0] cntReg;
   logic [31:0] sectMaskReg;
   logic [4:0] curSectReg;
   busWord_s busWordReg;
   logic [16:0] rdAddrReg;
   logic [7:0] rdDataReg;
   logic [7:0] lastStatusReg;
   logic pollReadReg;
   logic [15:0] pollCntReg;
   logic erasingReg;
   logic suspendedReg;
   logic doneReg;
   logic [15:0] gapCntReg;
   logic ctrlWr;
   logic [31:0] maskLeft;
   logic sectHold;
   logic pollDone;

   assign ctrlWr = regWr && (regAddr == REG_CTRL) && (stateReg == ST_IDLE);
   assign sectHold = (stateReg == ST_HOLD) && (opReg == OP_ERASE) && (stepReg == LAST_STEP);
   assign maskLeft = sectMaskReg & ~(32'h00000001 << curSectReg);
   assign pollDone = (stateReg == ST_SAMPLE) && pollReadReg && flashDqIn[POLL_BIT];

   // ****************************************
   // Sequencer
   // ****************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stateReg <= ST_IDLE;
         opReg <= OP_READ;
         stepReg <= 3'h0;
         cntReg <= 16'h0000;
         curSectReg <= 5'h00;
         busWordReg <= '0;
         pollReadReg <= 1'b0;
      end else begin
         case (stateReg)
            ST_IDLE: begin
               if (ctrlWr && regWrData[CTRL_HW_RESET]) begin
                  stateReg <= ST_RST;
                  cntReg <= RESET_PULSE_CYC - 16'h0001;
               end else if (ctrlWr && regWrData[CTRL_ERASE] && !erasingReg && sectMaskReg != 32'h0) begin
                  opReg <= OP_ERASE;
                  stepReg <= 3'h0;
                  curSectReg <= firstSet(sectMaskReg);
                  busWordReg <= seqWord(3'h0, 5'h00);
                  stateReg <= ST_SET;
               end else if (ctrlWr && regWrData[CTRL_SUSPEND] && erasingReg && !suspendedReg) begin
                  opReg <= OP_SUSPEND;
                  busWordReg <= '{UNLOCK_ADDR1, CMD_SUSPEND};
                  stateReg <= ST_SET;
               end else if (ctrlWr && regWrData[CTRL_RESUME] && suspendedReg) begin
                  opReg <= OP_RESUME;
                  busWordReg <= '{UNLOCK_ADDR1, CMD_RESUME};
                  stateReg <= ST_SET;
               end else if (ctrlWr && regWrData[CTRL_READ]) begin
                  opReg <= OP_READ;
                  pollReadReg <= 1'b0;
                  busWordReg <= '{rdAddrReg, 8'h00};
                  cntReg <= RD_CYC - 16'h0001;
                  stateReg <= ST_RD;
               end else if (erasingReg && !suspendedReg && pollCntReg == 16'h0000) begin
                  opReg <= OP_READ;
                  pollReadReg <= 1'b1;
                  busWordReg <= '{sectAddr(curSectReg), 8'h00};
                  cntReg <= RD_CYC - 16'h0001;
                  stateReg <= ST_RD;
               end
            end
            ST_SET: begin
               cntReg <= WE_CYC - 16'h0001;
               stateReg <= ST_WE;
            end
            ST_WE: begin
               cntReg <= cntReg - 16'h0001;
               if (cntReg == 16'h0000) begin
                  stateReg <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (opReg == OP_ERASE && stepReg != LAST_STEP) begin
                  stepReg <= stepReg + 3'h1;
                  busWordReg <= seqWord(stepReg + 3'h1, curSectReg);
                  stateReg <= ST_SET;
               end else if (opReg == OP_ERASE && maskLeft != 32'h0) begin
                  curSectReg <= firstSet(maskLeft);
                  busWordReg <= seqWord(LAST_STEP, firstSet(maskLeft));
                  stateReg <= ST_SET;
               end else if (opReg == OP_SUSPEND) begin
                  cntReg <= SUSPEND_CYC - 16'h0001;
                  stateReg <= ST_SUSP_WAIT;
               end else begin
                  stateReg <= ST_IDLE;
               end
            end
            ST_RD: begin
               cntReg <= cntReg - 16'h0001;
               if (cntReg == 16'h0000) begin
                  stateReg <= ST_SAMPLE;
               end
            end
            ST_SAMPLE: begin
               stateReg <= ST_IDLE;
            end
            ST_SUSP_WAIT: begin
               cntReg <= cntReg - 16'h0001;
               if (cntReg == 16'h0000) begin
                  stateReg <= ST_IDLE;
               end
            end
            ST_RST: begin
               cntReg <= cntReg - 16'h0001;
               if (cntReg == 16'h0000) begin
                  cntReg <= RESET_READY_CYC - 16'h0001;
                  stateReg <= ST_RST_WAIT;
               end
            end
            default: begin
               cntReg <= cntReg - 16'h0001;
               if (cntReg == 16'h0000) begin
                  stateReg <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // ****************************************
   // Sector queue and read address
   // ****************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sectMaskReg <= 32'h00000000;
         rdAddrReg <= 17'h00000;
      end else begin
         if (sectHold) begin
            sectMaskReg <= maskLeft;
         end else if (regWr && regAddr == REG_SECT_MASK) begin
            sectMaskReg <= regWrData;
         end
         if (regWr && regAddr == REG_RD_ADDR) begin
            rdAddrReg <= regWrData[16:0];
         end
      end
   end

   // ****************************************
   // Erase status
   // ****************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         erasingReg <= 1'b0;
         suspendedReg <= 1'b0;
         doneReg <= 1'b0;
         pollCntReg <= 16'h0000;
         lastStatusReg <= 8'h00;
         rdDataReg <= 8'h00;
      end else begin
         if (ctrlWr && regWrData[CTRL_HW_RESET]) begin
            erasingReg <= 1'b0;
            suspendedReg <= 1'b0;
         end else if (sectHold && maskLeft == 32'h0) begin
            erasingReg <= 1'b1;
            pollCntReg <= POLL_GAP_CYC;
         end else if (pollDone && erasingReg && !suspendedReg) begin
            erasingReg <= 1'b0;
         end else if (stateReg == ST_SUSP_WAIT && cntReg == 16'h0000) begin
            suspendedReg <= 1'b1;
         end else if (stateReg == ST_HOLD && opReg == OP_RESUME) begin
            suspendedReg <= 1'b0;
            pollCntReg <= POLL_GAP_CYC;
         end else if (stateReg == ST_SAMPLE && pollReadReg) begin
            pollCntReg <= POLL_GAP_CYC;
         end else if (pollCntReg != 16'h0000) begin
            pollCntReg <= pollCntReg - 16'h0001;
         end
         if (pollDone && erasingReg && !suspendedReg) begin
            doneReg <= 1'b1;
         end else if (regWr && regAddr == REG_CTRL && regWrData[CTRL_DONE_CLR]) begin
            doneReg <= 1'b0;
         end
         if (stateReg == ST_SAMPLE && pollReadReg) begin
            lastStatusReg <= flashDqIn;
         end else if (stateReg == ST_SAMPLE) begin
            rdDataReg <= flashDqIn;
         end
      end
   end

   // ****************************************
   // Register read port
   // ****************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         regRdData <= 32'h00000000;
      end else if (!regRd) begin
         regRdData <= 32'h00000000;
      end else if (regAddr == REG_SECT_MASK) begin
         regRdData <= sectMaskReg;
      end else if (regAddr == REG_RD_ADDR) begin
         regRdData <= {15'h0000, rdAddrReg};
      end else if (regAddr == REG_STATUS) begin
         regRdData <= {16'h0000, lastStatusReg, 4'h0, doneReg, suspendedReg, erasingReg, stateReg != ST_IDLE};
      end else if (regAddr == REG_RD_DATA) begin
         regRdData <= {24'h000000, rdDataReg};
      end else begin
         regRdData <= 32'h00000000;
      end
   end

   // ****************************************
   // Flash pins
   // ****************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         flashAddr <= 17'h00000;
         flashDqOut <= 8'h00;
         flashDqOe <= 1'b0;
         flashCeN <= 1'b1;
         flashOeN <= 1'b1;
         flashWeN <= 1'b1;
         flashResetN <= 1'b1;
      end else begin
         flashAddr <= busWordReg.addr;
         flashDqOut <= busWordReg.data;
         flashDqOe <= stateReg inside {ST_SET, ST_WE, ST_HOLD};
         flashCeN <= !(stateReg inside {ST_SET, ST_WE, ST_HOLD, ST_RD, ST_SAMPLE});
         flashOeN <= !(stateReg inside {ST_RD, ST_SAMPLE});
         flashWeN <= stateReg != ST_WE;
         flashResetN <= stateReg != ST_RST;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         gapCntReg <= 16'h0000;
      end else if (!flashWeN) begin
         gapCntReg <= 16'h0000;
      end else if (gapCntReg != 16'hffff) begin
         gapCntReg <= gapCntReg + 16'h0001;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   unlockFirst_a: assert property ($fell(flashWeN) && opReg == OP_ERASE && stepReg == 3'h0 |->
      flashAddr == UNLOCK_ADDR1 && flashDqOut == UNLOCK_DATA1 && flashDqOe) else $error("bad first unlock");
   setupCmd_a: assert property ($fell(flashWeN) && opReg == OP_ERASE && stepReg == 3'h2 |->
      flashAddr == UNLOCK_ADDR1 && flashDqOut == CMD_SETUP) else $error("bad setup write");
   sectorCmd_a: assert property ($fell(flashWeN) && opReg == OP_ERASE && stepReg == LAST_STEP |->
      flashDqOut == CMD_SECT_ERASE && flashAddr[11:0] == 12'h000) else $error("bad sector write");
   gapLimit_a: assert property ($fell(flashWeN) && opReg == OP_ERASE && stepReg == LAST_STEP |->
      gapCntReg < WINDOW_CYC) else $error("sector gap too long");
   queueAtomic_a: assert property ($rose(erasingReg) |->
      $past(stateReg) == ST_HOLD ##1 stateReg == ST_IDLE) else $error("queue not closed");
   noOtherCmd_a: assert property ($fell(flashWeN) && erasingReg && !suspendedReg |->
      flashDqOut == CMD_SUSPEND) else $error("foreign command during erase");
   resetAbort_a: assert property ($fell(flashResetN) |-> !erasingReg && !suspendedReg) else $error("erase kept over reset");
   resetPulse_a: assert property ($fell(flashResetN) |-> !flashResetN[*8] ##5 !flashResetN ##1 flashResetN)
      else $error("reset pulse length");

   eraseDone_c: cover property ($fell(erasingReg) && $rose(doneReg));
   suspendResume_c: cover property ($rose(suspendedReg) ##[1:1000] $fell(suspendedReg));
   multiSector_c: cover property ($fell(flashWeN) && stepReg == LAST_STEP ##[1:20] $fell(flashWeN) && stepReg == LAST_STEP);
   hwReset_c: cover property ($fell(flashResetN) && $past(erasingReg, 2));
endmodule : sector_erase_host

// ### tb/flash_dev_model.sv
`timescale 1ns/1ps
module flash_dev_model
   import flash_erase_pkg::*;
#(
   parameter int WIN_CYC = 1250,
   parameter int ERASE_CYC = 2000,
   parameter int SUSP_CYC = 100
)
(
   input wire logic clk_sys,
   input wire logic [16:0] flashAddr,
   input wire logic [7:0] flashDqOut,
   input wire logic flashCeN,
   input wire logic flashOeN,
   input wire logic flashWeN,
   input wire logic flashResetN,
   output logic [7:0] flashDqIn
);
   typedef enum logic [1:0] {M_READ, M_WINDOW, M_ERASE, M_SUSP} devMode_e;
   devMode_e mode = M_READ;
   logic [2:0] step = 3'h0;
   logic [31:0] queueMask = 32'h0;
   logic [31:0] erasedMask = 32'h0;
   int seqErr = 0;
   int timer = 0;
   int suspWait = 0;
   logic weNPrev = 1'b1;
   logic oeNPrev = 1'b1;
   logic togBit = 1'b0;
   logic sectTog = 1'b0;
   logic wCe = 1'b0;
   logic [16:0] wAddr = 17'h0;
   logic [7:0] wData = 8'h0;
   logic [7:0] lastDq = 8'h0;
   logic [7:0] rdVal;
   logic [16:0] expAddr;
   logic [7:0] expData;
   logic hit;
   // ****************************************
   // Read path
   // ****************************************
   // sector from upper bits
   assign hit = queueMask[flashAddr[16:12]];
   always_comb begin
      if (mode == M_READ || (mode == M_SUSP && !hit)) begin
         rdVal = erasedMask[flashAddr[16:12]] ? 8'hff : (flashAddr[7:0] ^ 8'h3c);
      end else begin
         rdVal = {mode == M_SUSP, togBit, 2'b00, mode != M_WINDOW, sectTog, 2'b00};
      end
   end
   assign flashDqIn = (!flashCeN && !flashOeN && flashResetN) ? rdVal : ~lastDq;
   assign expAddr = (step == 3'h1 || step == 3'h4) ? UNLOCK_ADDR2 : UNLOCK_ADDR1;
   assign expData = (step == 3'h1 || step == 3'h4) ? UNLOCK_DATA2 : (step == 3'h2 ? CMD_SETUP : UNLOCK_DATA1);
   // ****************************************
   // Command state
   // ****************************************
   always @(posedge clk_sys) begin
      weNPrev <= flashWeN;
      oeNPrev <= flashOeN;
      if (!flashCeN && !flashOeN) begin
         lastDq <= rdVal;
      end
      if (!oeNPrev && flashOeN) begin
         if (mode == M_WINDOW || mode == M_ERASE) begin
            togBit <= ~togBit;
         end
         if (mode != M_READ && hit) begin
            sectTog <= ~sectTog;
         end
      end
      if (!flashWeN) begin
         wAddr <= flashAddr;
         wData <= flashDqOut;
         wCe <= !flashCeN;
      end
      if (!flashResetN) begin
         mode <= M_READ;
         step <= 3'h0;
         queueMask <= 32'h0;
         suspWait <= 0;
      end else begin
         if (mode == M_WINDOW) begin
            timer <= timer + 1;
            if (timer >= WIN_CYC) begin
               mode <= M_ERASE;
               timer <= 0;
            end
         end
         if (mode == M_ERASE) begin
            timer <= timer + 1;
            if (suspWait > 0) begin
               suspWait <= suspWait - 1;
            end
            if (suspWait == 1) begin
               mode <= M_SUSP;
            end else if (timer >= ERASE_CYC) begin
               mode <= M_READ;
               erasedMask <= erasedMask | queueMask;
               queueMask <= 32'h0;
            end
         end
         if (!weNPrev && flashWeN && wCe) begin
            case (mode)
               M_READ: begin
                  if (step == LAST_STEP && wData == CMD_SECT_ERASE) begin
                     queueMask <= 32'h1 << wAddr[16:12];
                     mode <= M_WINDOW;
                     timer <= 0;
                     step <= 3'h0;
                  end else if (step != LAST_STEP && wAddr[10:0] == expAddr[10:0] && wData == expData) begin
                     step <= step + 3'h1;
                  end else begin
                     step <= 3'h0;
                     seqErr <= seqErr + 1;
                  end
               end
               M_WINDOW: begin
                  if (wData == CMD_SECT_ERASE) begin
                     queueMask <= queueMask | (32'h1 << wAddr[16:12]);
                     timer <= 0;
                  end else if (wData == CMD_SUSPEND) begin
                     mode <= M_SUSP;
                  end else begin
                     mode <= M_READ;
                     queueMask <= 32'h0;
                  end
               end
               M_ERASE: begin
                  if (wData == CMD_SUSPEND && suspWait == 0) begin
                     suspWait <= SUSP_CYC;
                  end
               end
               default: begin
                  if (wData == CMD_RESUME) begin
                     mode <= M_ERASE;
                  end
               end
            endcase
         end
      end
   end
endmodule : flash_dev_model

// ### tb/tb.sv
`timescale 1ns/1ps
module tb
   import flash_erase_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst, regWr, regRd;
   logic [7:0] regAddr;
   logic [31:0] regWrData, regRdData, d;
   logic [16:0] flashAddr;
   logic [7:0] flashDqIn, flashDqOut;
   logic flashDqOe, flashCeN, flashOeN, flashWeN, flashResetN;
   int numErrors = 0;
   int nTests = 0;

   always #20 clk_sys = ~clk_sys;

   sector_erase_host i_sector_erase_host (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .flashAddr(flashAddr),
      .flashDqIn(flashDqIn), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashCeN(flashCeN),
      .flashOeN(flashOeN), .flashWeN(flashWeN), .flashResetN(flashResetN));
   flash_dev_model i_flash_dev_model (.clk_sys(clk_sys), .flashAddr(flashAddr), .flashDqOut(flashDqOut),
      .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN), .flashResetN(flashResetN),
      .flashDqIn(flashDqIn));
   always @(negedge clk_sys) begin
      if (!flashWeN) begin
         check("data drive", {31'h0, flashDqOe}, 32'h1);
      end
      if (!flashOeN) begin
         check("data release", {31'h0, flashDqOe}, 32'h0);
      end
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic summarize();
      $display("Comparisons %0d mismatches %0d", nTests, numErrors);
      if (numErrors == 0 && nTests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : summarize
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp) begin
         numErrors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= v;
      regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_sys);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1 v = regRdData;
   endtask : rd
   task automatic waitBit(input int b, input logic v);
      logic [31:0] s;
      for (int i = 0; i < 400; i++) begin
         rd(REG_STATUS, s);
         if (s[b] === v) break;
         repeat (50) @(posedge clk_sys);
      end
      check("status bit", {31'h0, s[b]}, {31'h0, v});
   endtask : waitBit
   task automatic readFlash(input logic [16:0] a, output logic [31:0] v);
      wr(REG_RD_ADDR, {15'h0, a});
      wr(REG_CTRL, 32'h1 << CTRL_READ);
      waitBit(0, 1'b0);
      rd(REG_RD_DATA, v);
   endtask : readFlash
   task automatic modeIs(input logic [1:0] m);
      check("device mode", {30'h0, i_flash_dev_model.mode}, {30'h0, m});
   endtask : modeIs
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (60000) @(posedge clk_sys);
      numErrors++;
      summarize();
   end
   initial begin
      rst = 1'b1;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 8'h00;
      regWrData = 32'h0;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      rd(REG_STATUS, d);
      check("status reset", d, 32'h0);
      rd(REG_SECT_MASK, d);
      check("mask reset", d, 32'h0);
      rd(8'h14, d);
      check("unmapped read", d, 32'h0);
      wr(REG_SECT_MASK, 32'h80000001);
      rd(REG_SECT_MASK, d);
      check("mask readback", d, 32'h80000001);
      $display("Test reset done");
      wr(REG_CTRL, 32'h1 << CTRL_ERASE);
      repeat (200) @(posedge clk_sys);
      rd(REG_STATUS, d);
      check("erasing flag", {31'h0, d[1]}, 32'h1);
      check("erasing poll bit", {31'h0, d[15]}, 32'h0);
      check("window flag", {31'h0, d[11]}, 32'h0);
      waitBit(3, 1'b1);
      check("sequence errors", 32'(i_flash_dev_model.seqErr), 32'h0);
      check("erased sectors", i_flash_dev_model.erasedMask, 32'h80000001);
      rd(REG_SECT_MASK, d);
      check("mask drained", d, 32'h0);
      rd(REG_STATUS, d);
      check("status done", {16'h0, d[15:0]}, 32'hff08);
      wr(REG_CTRL, 32'h1 << CTRL_DONE_CLR);
      rd(REG_STATUS, d);
      check("done cleared", {31'h0, d[3]}, 32'h0);
      $display("Test erase done");
      wr(REG_SECT_MASK, 32'h4);
      wr(REG_CTRL, 32'h1 << CTRL_ERASE);
      waitBit(0, 1'b0);
      wr(REG_CTRL, 32'h1 << CTRL_SUSPEND);
      waitBit(0, 1'b0);
      modeIs(2'd3);
      rd(REG_STATUS, d);
      check("suspended flag", {31'h0, d[2]}, 32'h1);
      readFlash(17'h02010, d);
      check("suspended poll bit", {31'h0, d[7]}, 32'h1);
      readFlash(17'h05021, d);
      check("array read", d, 32'h1d);
      wr(REG_CTRL, 32'h1 << CTRL_RESUME);
      waitBit(0, 1'b0);
      modeIs(2'd2);
      wr(REG_CTRL, 32'h1 << CTRL_SUSPEND);
      waitBit(0, 1'b0);
      modeIs(2'd3);
      wr(REG_CTRL, 32'h1 << CTRL_RESUME);
      waitBit(3, 1'b1);
      check("erased after resume", i_flash_dev_model.erasedMask, 32'h80000005);
      wr(REG_CTRL, 32'h1 << CTRL_DONE_CLR);
      $display("Test suspend done");
      wr(REG_SECT_MASK, 32'h10);
      wr(REG_CTRL, 32'h1 << CTRL_ERASE);
      waitBit(0, 1'b0);
      wr(REG_CTRL, 32'h1 << CTRL_HW_RESET);
      waitBit(0, 1'b0);
      modeIs(2'd0);
      check("aborted sector", i_flash_dev_model.erasedMask, 32'h80000005);
      rd(REG_STATUS, d);
      check("erasing cleared", {31'h0, d[1]}, 32'h0);
      $display("Test hardware reset done");
      summarize();
   end
endmodule : tb
